// ==== dgp_pkg.sv ====
// Shared constants, register map and carrier types of the gain processor.
package dgp_pkg;

  // ---------------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ---------------------------------------------------------------------
  localparam int         ADDR_W      = 4;
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_THRESH  = 4'h1;
  localparam logic [3:0] REG_RATIO   = 4'h2;
  localparam logic [3:0] REG_ATTACK  = 4'h3;
  localparam logic [3:0] REG_OUTGAIN = 4'h4;
  localparam logic [3:0] REG_KNEE    = 4'h5;
  localparam logic [3:0] REG_RELEASE = 4'h6;
  localparam logic [3:0] REG_WIDTH   = 4'h7;
  localparam logic [3:0] REG_STATUS  = 4'h8;

  // Control register fields.
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_FS_LSB   = 3;
  localparam int CTRL_KEY_LSB  = 5;
  // Status register fields.
  localparam int STAT_TRIG_BIT = 0;
  localparam int STAT_GR_LSB   = 8;

  // ---------------------------------------------------------------------
  // Parameter code ranges and reset values
  // ---------------------------------------------------------------------
  localparam int THRESH_MAX     = 54;
  localparam int RATIO_MAX      = 15;
  localparam int RATIO_CMPD_MAX = 14;
  localparam int ATTACK_MAX     = 120;
  localparam int OUTGAIN_MAX    = 36;
  localparam int KNEE_MAX       = 5;
  localparam int RELEASE_MAX    = 159;
  localparam int WIDTH_MIN      = 1;
  localparam int WIDTH_MAX      = 90;

  localparam logic [5:0] THRESH_RST  = 6'h14;
  localparam logic [3:0] RATIO_RST   = 4'h5;
  localparam logic [6:0] ATTACK_RST  = 7'h0A;
  localparam logic [5:0] OUTGAIN_RST = 6'h00;
  localparam logic [2:0] KNEE_RST    = 3'h0;
  localparam logic [7:0] RELEASE_RST = 8'h30;
  localparam logic [6:0] WIDTH_RST   = 7'h5A;

  // ---------------------------------------------------------------------
  // Level arithmetic; levels and gains in half-decibel units
  // ---------------------------------------------------------------------
  localparam int HDB_PER_DB      = 2;
  localparam int HDB_PER_SHIFT   = 12;
  localparam int LEVEL_FLOOR     = -288;
  localparam int GR_CEIL         = 400;
  localparam int OUTGAIN_OFFSET  = 36;
  localparam int OUT_SHIFT       = 3;
  localparam int MUTE_SHIFT      = 24;
  localparam int CMPD_HARD_EXP_F = 64;
  localparam int CMPD_SOFT_EXP_F = 8;
  localparam int SAMPLE_W        = 24;

  // ---------------------------------------------------------------------
  // Envelope timing, counted in audio samples
  // ---------------------------------------------------------------------
  localparam int SPM_48K      = 48;
  localparam int SPM_44K1     = 44;
  localparam int SPM_32K      = 32;
  localparam int ATTACK_SHIFT = 3;
  localparam int REL_PER_OCT  = 12;
  localparam int CNT_W        = 17;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    compress_mode, expand_mode, hard_compand_mode, soft_compand_mode
  } dgp_mode_e;

  typedef enum logic [2:0] {
    key_self_post, key_self_pre, key_left_post, key_left_pre,
    key_aux1, key_aux2
  } dgp_key_e;

  typedef struct packed {
    logic                 enable;
    dgp_mode_e            mode;
    logic [1:0]           fs;
    dgp_key_e             key;
    logic [5:0]           thresh;
    logic [3:0]           ratio;
    logic [6:0]           attack;
    logic [5:0]           outgain;
    logic [2:0]           knee;
    logic [7:0]           release_code;
    logic [6:0]           width;
  } dgp_cfg_s;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] self_post;
    logic signed [SAMPLE_W-1:0] self_pre;
    logic signed [SAMPLE_W-1:0] left_post;
    logic signed [SAMPLE_W-1:0] left_pre;
    logic signed [SAMPLE_W-1:0] aux1;
    logic signed [SAMPLE_W-1:0] aux2;
  } dgp_key_s;

endpackage

// ==== dgp_dynamics_gain_processor.sv ====
// Per-channel compressor, expander and compander with envelope and out gain.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module dgp_dynamics_gain_processor
  import dgp_pkg::*;
#(
  parameter bit HAS_LEFT = 1'b1
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic [ADDR_W-1:0]          reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output      logic [31:0]                reg_rdata,
  input  wire logic                       in_valid,
  input  wire logic signed [SAMPLE_W-1:0] in_sample,
  input  wire dgp_key_s                   key_samples,
  output      logic                       out_valid,
  output      logic signed [SAMPLE_W-1:0] out_sample
);

  // ---------------------------------------------------------------------
  // Arithmetic helpers
  // ---------------------------------------------------------------------

  // Coarse log level: 12 half-dB per octave plus three fraction bits.
  function automatic int level_of(logic signed [SAMPLE_W-1:0] x);
    logic [SAMPLE_W-2:0] m;
    int                  p;
    int                  f;
    m = x[SAMPLE_W-1] ? (SAMPLE_W-1)'(-x) : x[SAMPLE_W-2:0];
    if (x == {1'b1, {(SAMPLE_W-1){1'b0}}}) begin
      m = '1;
    end
    p = 0;
    f = 0;
    for (int i = 0; i < SAMPLE_W - 1; i++) begin
      if (m[i]) begin
        p = i;
      end
    end
    if (p >= 3) begin
      f = int'(3'(m >> (p - 3)));
    end
    if (m == '0) begin
      return LEVEL_FLOOR;
    end
    return HDB_PER_SHIFT * (p - (SAMPLE_W - 2)) + ((f * 3) >> 1);
  endfunction

  // Part of e that lies past a knee; soft knees blend quadratically.
  function automatic int excess(int e, int knee);
    int w;
    int q;
    w = 1 << knee;
    q = e + w;
    if (knee == 0) begin
      return (e > 0) ? e : 0;
    end
    if (e <= -w) begin
      return 0;
    end
    if (e >= w) begin
      return e;
    end
    return (q * q) >> (knee + 2);
  endfunction

  // Compression slope 1 - 1/ratio in units of 1/256.
  function automatic int comp_slope(logic [3:0] code);
    case (code)
      4'h0: return 0;
      4'h1: return 23;
      4'h2: return 59;
      4'h3: return 85;
      4'h4: return 105;
      4'h5: return 128;
      4'h6: return 154;
      4'h7: return 171;
      4'h8: return 183;
      4'h9: return 192;
      4'hA: return 205;
      4'hB: return 213;
      4'hC: return 224;
      4'hD: return 230;
      4'hE: return 243;
      default: return 256;
    endcase
  endfunction

  // Expansion factor ratio - 1 in units of 1/16; infinity saturates.
  function automatic int exp_factor(logic [3:0] code);
    case (code)
      4'h0: return 0;
      4'h1: return 2;
      4'h2: return 5;
      4'h3: return 8;
      4'h4: return 11;
      4'h5: return 16;
      4'h6: return 24;
      4'h7: return 32;
      4'h8: return 40;
      4'h9: return 48;
      4'hA: return 64;
      4'hB: return 80;
      4'hC: return 112;
      4'hD: return 144;
      4'hE: return 304;
      default: return 4095;
    endcase
  endfunction

  // Linear factor for 0..11 half-dB of attenuation, Q15.
  function automatic int hdb_mult(int r);
    case (r)
      0: return 32768;
      1: return 30934;
      2: return 29205;
      3: return 27571;
      4: return 26029;
      5: return 24573;
      6: return 23198;
      7: return 21900;
      8: return 20675;
      9: return 19519;
      10: return 18427;
      default: return 17397;
    endcase
  endfunction

  function automatic logic [6:0] clamp7(logic [31:0] v, int lo, int hi);
    if (v < 32'(lo)) begin
      return 7'(lo);
    end
    if (v > 32'(hi)) begin
      return 7'(hi);
    end
    return v[6:0];
  endfunction

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  dgp_cfg_s           cfg_q;
  logic               trig_q;
  logic signed [12:0] gain_q;
  logic [31:0]        rd_val;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_q.enable       <= 1'b0;
      cfg_q.mode         <= compress_mode;
      cfg_q.fs           <= 2'h0;
      cfg_q.key          <= key_self_post;
      cfg_q.thresh       <= THRESH_RST;
      cfg_q.ratio        <= RATIO_RST;
      cfg_q.attack       <= ATTACK_RST;
      cfg_q.outgain      <= OUTGAIN_RST;
      cfg_q.knee         <= KNEE_RST;
      cfg_q.release_code <= RELEASE_RST;
      cfg_q.width        <= WIDTH_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: begin
          cfg_q.enable <= reg_wdata[CTRL_EN_BIT];
          cfg_q.mode   <= dgp_mode_e'(reg_wdata[CTRL_MODE_LSB +: 2]);
          cfg_q.fs     <= reg_wdata[CTRL_FS_LSB +: 2];
          // Codes 6 and 7 name no source and fall back to the own channel.
          if (reg_wdata[CTRL_KEY_LSB +: 3] > 3'h5) begin
            cfg_q.key <= key_self_post;
          end else begin
            cfg_q.key <= dgp_key_e'(reg_wdata[CTRL_KEY_LSB +: 3]);
          end
        end
        REG_THRESH: cfg_q.thresh <= 6'(clamp7(reg_wdata, 0, THRESH_MAX));
        REG_RATIO:  cfg_q.ratio  <= reg_wdata[3:0];
        REG_ATTACK: cfg_q.attack <= clamp7(reg_wdata, 0, ATTACK_MAX);
        REG_OUTGAIN: begin
          cfg_q.outgain <= 6'(clamp7(reg_wdata, 0, OUTGAIN_MAX));
        end
        REG_KNEE:   cfg_q.knee   <= 3'(clamp7(reg_wdata, 0, KNEE_MAX));
        REG_RELEASE: begin
          if (reg_wdata > 32'(RELEASE_MAX)) begin
            cfg_q.release_code <= 8'(RELEASE_MAX);
          end else begin
            cfg_q.release_code <= reg_wdata[7:0];
          end
        end
        REG_WIDTH: begin
          cfg_q.width <= clamp7(reg_wdata, WIDTH_MIN, WIDTH_MAX);
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    rd_val = 32'h0;
    unique case (reg_addr)
      REG_CTRL: begin
        rd_val[CTRL_EN_BIT]        = cfg_q.enable;
        rd_val[CTRL_MODE_LSB +: 2] = cfg_q.mode;
        rd_val[CTRL_FS_LSB +: 2]   = cfg_q.fs;
        rd_val[CTRL_KEY_LSB +: 3]  = cfg_q.key;
      end
      REG_THRESH:  rd_val[5:0] = cfg_q.thresh;
      REG_RATIO:   rd_val[3:0] = cfg_q.ratio;
      REG_ATTACK:  rd_val[6:0] = cfg_q.attack;
      REG_OUTGAIN: rd_val[5:0] = cfg_q.outgain;
      REG_KNEE:    rd_val[2:0] = cfg_q.knee;
      REG_RELEASE: rd_val[7:0] = cfg_q.release_code;
      REG_WIDTH:   rd_val[6:0] = cfg_q.width;
      REG_STATUS: begin
        rd_val[STAT_TRIG_BIT]      = trig_q;
        rd_val[STAT_GR_LSB +: 13]  = 13'(-gain_q);
      end
      default: rd_val = 32'h0;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 32'h0;
    end
  end

  // ---------------------------------------------------------------------
  // Stage 1: side-chain select and level detection
  // ---------------------------------------------------------------------
  logic                       v1_q;
  logic                       v2_q;
  logic signed [SAMPLE_W-1:0] x1_q;
  logic signed [SAMPLE_W-1:0] x2_q;
  logic signed [SAMPLE_W-1:0] key_x;
  logic signed [SAMPLE_W-1:0] key1_q;
  logic signed [12:0]         level_q;

  always_comb begin
    unique case (cfg_q.key)
      key_self_pre:  key_x = key_samples.self_pre;
      key_left_post: key_x = HAS_LEFT ? key_samples.left_post
                                      : key_samples.self_post;
      key_left_pre:  key_x = HAS_LEFT ? key_samples.left_pre
                                      : key_samples.self_pre;
      key_aux1:      key_x = key_samples.aux1;
      key_aux2:      key_x = key_samples.aux2;
      default:       key_x = key_samples.self_post;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      v1_q <= 1'b0;
      v2_q <= 1'b0;
    end else begin
      v1_q <= in_valid;
      v2_q <= v1_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      x1_q    <= '0;
      x2_q    <= '0;
      key1_q  <= '0;
      level_q <= 13'(LEVEL_FLOOR);
    end else begin
      x1_q    <= in_sample;
      x2_q    <= x1_q;
      // The key is staged like the sample, so the level lines up with x2_q.
      key1_q  <= key_x;
      level_q <= 13'(level_of(key1_q));
    end
  end

  // ---------------------------------------------------------------------
  // Stage 2: static gain curve
  // ---------------------------------------------------------------------
  int                 thr;
  int                 over;
  int                 under;
  int                 gr;
  int                 cmpd_f;
  logic [3:0]         cmpd_ratio;
  logic               trig;
  logic signed [12:0] target;

  always_comb begin
    thr        = -HDB_PER_DB * int'(cfg_q.thresh);
    over       = int'(level_q) - thr;
    under      = thr - int'(level_q);
    gr         = 0;
    trig       = 1'b0;
    cmpd_ratio = (cfg_q.ratio > 4'(RATIO_CMPD_MAX)) ? 4'(RATIO_CMPD_MAX)
                                                    : cfg_q.ratio;
    cmpd_f     = (cfg_q.mode == hard_compand_mode) ? CMPD_HARD_EXP_F
                                                   : CMPD_SOFT_EXP_F;
    unique case (cfg_q.mode)
      compress_mode: begin
        trig = over >= 0;
        gr   = (excess(over, int'(cfg_q.knee)) *
                comp_slope(cfg_q.ratio)) >> 8;
      end
      expand_mode: begin
        trig = under >= 0;
        gr   = (excess(under, int'(cfg_q.knee)) *
                exp_factor(cfg_q.ratio)) >> 4;
      end
      default: begin
        trig = over >= 0;
        gr   = (excess(over, 0) * comp_slope(cmpd_ratio)) >> 8;
        if (cfg_q.width < 7'(WIDTH_MAX)) begin
          gr = gr + ((excess(under - HDB_PER_DB * int'(cfg_q.width), 0) *
                      cmpd_f) >> 4);
        end
      end
    endcase
    if (gr > GR_CEIL) begin
      gr = GR_CEIL;
    end
    target = 13'(-gr);
  end

  // ---------------------------------------------------------------------
  // Envelope: attack moves gain down, release moves it back up
  // ---------------------------------------------------------------------
  logic [CNT_W-1:0]   step_cnt_q;
  logic [CNT_W-1:0]   atk_period;
  logic [CNT_W-1:0]   rel_period;
  logic               step;
  logic               moving;
  logic signed [12:0] gain_d;
  int                 spm;
  int                 rel_e;
  int                 rel_m;

  always_comb begin
    unique case (cfg_q.fs)
      2'h1:    spm = SPM_44K1;
      2'h2:    spm = SPM_32K;
      default: spm = SPM_48K;
    endcase
    atk_period = CNT_W'((int'(cfg_q.attack) * spm) >> ATTACK_SHIFT);
    if (atk_period == '0) begin
      atk_period = CNT_W'(1);
    end
    // Release codes are sample counts, so the same code is slower at 32 kHz.
    rel_e      = int'(cfg_q.release_code) / REL_PER_OCT;
    rel_m      = int'(cfg_q.release_code) % REL_PER_OCT;
    rel_period = CNT_W'(((REL_PER_OCT + rel_m) << rel_e) >> 1);
    moving     = v2_q && (target != gain_q);
    step       = 1'b0;
    gain_d     = gain_q;
    if (v2_q && target < gain_q) begin
      if (cfg_q.attack == '0) begin
        gain_d = target;
      end else if (step_cnt_q >= atk_period - CNT_W'(1)) begin
        step   = 1'b1;
        gain_d = gain_q - 13'sd1;
      end
    end else if (v2_q && target > gain_q) begin
      if (step_cnt_q >= rel_period - CNT_W'(1)) begin
        step   = 1'b1;
        gain_d = gain_q + 13'sd1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      step_cnt_q <= '0;
    end else if (v2_q) begin
      step_cnt_q <= (step || !moving) ? '0 : step_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gain_q <= '0;
      trig_q <= 1'b0;
    end else if (v2_q) begin
      gain_q <= gain_d;
      trig_q <= trig;
    end
  end

  // ---------------------------------------------------------------------
  // Stage 3: apply gain and out gain
  // ---------------------------------------------------------------------
  int                 og;
  int                 att;
  int                 att_sh;
  logic signed [47:0] prod;
  logic signed [47:0] scaled;

  always_comb begin
    if (cfg_q.mode == compress_mode || cfg_q.mode == expand_mode) begin
      og = int'(cfg_q.outgain);
    end else begin
      og = -int'(cfg_q.outgain);
    end
    // The fixed left shift for out gain comes first, so unity loses no bit.
    att    = OUTGAIN_OFFSET - og - int'(gain_d);
    att_sh = att / HDB_PER_SHIFT;
    prod   = 48'(x2_q) * 48'(hdb_mult(att % HDB_PER_SHIFT));
    scaled = (prod <<< OUT_SHIFT) >>> 15;
    scaled = scaled >>> att_sh;
    if (att_sh >= MUTE_SHIFT) begin
      scaled = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_valid  <= 1'b0;
      out_sample <= '0;
    end else begin
      out_valid <= v2_q;
      if (v2_q) begin
        if (!cfg_q.enable) begin
          out_sample <= x2_q;
        end else if (scaled > 48'(2**(SAMPLE_W-1) - 1)) begin
          out_sample <= {1'b0, {(SAMPLE_W-1){1'b1}}};
        end else if (scaled < -48'(2**(SAMPLE_W-1))) begin
          out_sample <= {1'b1, {(SAMPLE_W-1){1'b0}}};
        end else begin
          out_sample <= SAMPLE_W'(scaled);
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence bypass_s;
    (in_valid && !cfg_q.enable && !reg_wr) ##1 (!cfg_q.enable && !reg_wr)
      ##1 !cfg_q.enable;
  endsequence

  stream_latency_a: assert property (in_valid |-> ##3 out_valid)
    else $error("sample did not leave three cycles after entry");
  bypass_pass_a: assert property (bypass_s |=>
      out_sample == $past(in_sample, 3))
    else $error("disabled processor altered the sample");
  comp_below_a: assert property (v2_q && cfg_q.mode == compress_mode &&
      cfg_q.knee == '0 && over < 0 |-> target == '0)
    else $error("compressor acted below threshold");
  comp_slope_a: assert property (v2_q && cfg_q.mode == compress_mode &&
      cfg_q.knee == '0 && cfg_q.ratio == 4'h5 && over >= 0 && over < 400
      |-> int'(target) == -(over / 2))
    else $error("compressor 2:1 slope wrong");
  exp_above_a: assert property (v2_q && cfg_q.mode == expand_mode &&
      cfg_q.knee == '0 && under < 0 |-> target == '0)
    else $error("expander acted above threshold");
  exp_slope_a: assert property (v2_q && cfg_q.mode == expand_mode &&
      cfg_q.knee == '0 && cfg_q.ratio == 4'h5 && under >= 0 && under < 400
      |-> int'(target) == -under)
    else $error("expander 1:2 slope wrong");
  attack_jump_a: assert property (v2_q && cfg_q.attack == '0 &&
      target < gain_q |=> gain_q == $past(target))
    else $error("zero attack did not act at once");
  release_step_a: assert property (v2_q && target > gain_q |=>
      (gain_q == $past(gain_q) || gain_q == $past(gain_q) + 13'sd1))
    else $error("release moved gain by more than one step");
  width_off_a: assert property (v2_q && cfg_q.mode inside
      {hard_compand_mode, soft_compand_mode} &&
      cfg_q.width == 7'(WIDTH_MAX) && over < 0 |-> target == '0)
    else $error("compander expanded at maximum width");

endmodule

// ==== dgp_mixer_model.sv ====
// Behavioural model of the mixing datapath that feeds and drains samples.
`timescale 1ns/1ps
module dgp_mixer_model
  import dgp_pkg::*;
(
  input  wire logic                       clk,
  output      logic                       in_valid,
  output      logic signed [SAMPLE_W-1:0] in_sample,
  output      dgp_key_s                   key_samples,
  input  wire logic                       out_valid,
  input  wire logic signed [SAMPLE_W-1:0] out_sample
);
  initial begin
    in_valid    = 1'b0;
    in_sample   = '0;
    key_samples = '0;
  end
  // Lines carry inverted data between strobes, so a late capture shows up.
  task automatic send(input logic signed [SAMPLE_W-1:0] s,
                      input dgp_key_s k,
                      output logic signed [SAMPLE_W-1:0] got,
                      output int lat);
    lat = 0;
    got = '0;
    @(posedge clk);
    in_valid    <= 1'b1;
    in_sample   <= s;
    key_samples <= k;
    @(posedge clk);
    in_valid    <= 1'b0;
    in_sample   <= ~s;
    key_samples <= ~k;
    for (int i = 1; i <= 8 && lat == 0; i++) begin
      #1;
      if (out_valid === 1'b1) begin
        lat = i;
        got = out_sample;
      end else begin
        @(posedge clk);
      end
    end
  endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the dynamics gain processor.
`timescale 1ns/1ps
module testbench
  import dgp_pkg::*;
;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [3:0]        reg_addr = '0;
  logic [31:0]       reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [31:0]       reg_rdata;
  logic              in_valid;
  logic signed [23:0] in_sample;
  dgp_key_s          key_samples;
  logic              out_valid;
  logic signed [23:0] out_sample;
  int                fails = 0;
  int                compares = 0;
  always #2.5 clk = ~clk;
  dgp_dynamics_gain_processor uut (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_sample(in_sample), .key_samples(key_samples),
    .out_valid(out_valid), .out_sample(out_sample));
  dgp_mixer_model mix (.clk(clk), .in_valid(in_valid),
    .in_sample(in_sample), .key_samples(key_samples),
    .out_valid(out_valid), .out_sample(out_sample));
  // ---------------------------------------------------------------------
  // Bus, stream and compare helpers
  // ---------------------------------------------------------------------
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic snd(input logic signed [23:0] s, input logic signed [23:0] ax,
                     output logic signed [23:0] g);
    dgp_key_s k;
    int       lat;
    k = '0;
    k.self_post = s;
    k.aux1 = ax;
    mix.send(s, k, g, lat);
    chk("latency", 3, lat);
    if (lat == 0) complete_run();
  endtask
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_regs;
    logic [3:0]  a[8] = '{REG_THRESH, REG_RATIO, REG_ATTACK, REG_OUTGAIN,
                          REG_KNEE, REG_RELEASE, REG_WIDTH, 4'hF};
    logic [31:0] e[8] = '{32'h14, 32'h5, 32'hA, 32'h0, 32'h0, 32'h30,
                          32'h5A, 32'h0};
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(a[i], d);
      chk("reset value", e[i], d);
    end
    wr(REG_THRESH, 32'hFF);
    rd(REG_THRESH, d);
    chk("threshold clamp", 32'h36, d);
    wr(REG_THRESH, 32'h14);
    $display("test regs done");
  endtask
  task automatic t_pass;
    logic signed [23:0] g;
    wr(REG_CTRL, 32'h0);
    snd(24'h123456, 24'h0, g);
    chk("bypass", 32'h123456, g);
    wr(REG_ATTACK, 32'h0);
    wr(REG_CTRL, 32'h3);
    snd(24'h700000, 24'h0, g);
    chk("expander above", 32'h700000, g);
    wr(REG_CTRL, 32'h1);
    snd(24'h001000, 24'h0, g);
    chk("compressor below", 32'h1000, g);
    wr(REG_OUTGAIN, 32'hC);
    snd(24'h001000, 24'h0, g);
    chk("out gain raises", 1, g > 24'sh001000);
    wr(REG_OUTGAIN, 32'h0);
    $display("test pass done");
  endtask
  task automatic t_key;
    logic signed [23:0] g;
    logic [31:0]        d;
    wr(REG_CTRL, 32'h81);
    snd(24'h001000, 24'h7FFFFF, g);
    snd(24'h001000, 24'h7FFFFF, g);
    chk("aux key reduces", 1, g < 24'sh001000);
    rd(REG_STATUS, d);
    chk("triggered", 1, d[STAT_TRIG_BIT]);
    $display("test key done");
  endtask
  task automatic t_exp;
    logic signed [23:0] g;
    wr(REG_CTRL, 32'h3);
    snd(24'h001000, 24'h0, g);
    chk("expander below", 1, g > 24'sh000010 && g < 24'sh000040);
    wr(REG_CTRL, 32'h1);
    snd(24'h001000, 24'h0, g);
    chk("slow release", 1, g < 24'sh000080);
    $display("test exp done");
  endtask
  task automatic t_cmpd;
    logic signed [23:0] g;
    logic [31:0]        d;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(REG_ATTACK, d);
    chk("reset value", 32'hA, d);
    wr(REG_ATTACK, 32'h0);
    wr(REG_CTRL, 32'h7);
    wr(REG_OUTGAIN, 32'hC);
    snd(24'h001000, 24'h0, g);
    chk("compander out gain", 32'h800, g);
    wr(REG_OUTGAIN, 32'h0);
    wr(REG_WIDTH, 32'h1);
    snd(24'h001000, 24'h0, g);
    chk("soft compander", 1, g > 24'sh000180 && g < 24'sh000200);
    wr(REG_CTRL, 32'h5);
    snd(24'h001000, 24'h0, g);
    chk("hard compander", 32'h0, g);
    $display("test compander done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_pass();
    t_key();
    t_exp();
    t_cmpd();
    complete_run();
  end
endmodule
